/* common/dma_regs_pkg.sv */
/*
  Holds the shared constants and types of the four-channel DMA register set:
  register byte offsets, field positions, masks, reset values, mode codes and
  the transfer request carrier.
  Assumes a 32-bit AXI4-Lite register bus whose byte addresses fit in eight bits.
*/
`default_nettype none
package dma_regs_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;

  // Per-channel register index inside a channel window of 0x20 bytes.
  localparam logic [2:0] IDX_CON = 3'h0;
  localparam logic [2:0] IDX_REQ = 3'h1;
  localparam logic [2:0] IDX_STAH = 3'h2;
  localparam logic [2:0] IDX_STAL = 3'h3;
  localparam logic [2:0] IDX_STBH = 3'h4;
  localparam logic [2:0] IDX_STBL = 3'h5;
  localparam logic [2:0] IDX_PAD = 3'h6;
  localparam logic [2:0] IDX_CNT = 3'h7;

  // Shared status words above the channel windows.
  localparam logic [7:0] OFS_PWC = 8'h80;
  localparam logic [7:0] OFS_RQC = 8'h84;
  localparam logic [7:0] OFS_PPS = 8'h88;
  localparam logic [7:0] OFS_LCA = 8'h8C;
  localparam logic [7:0] OFS_RECENT_LO = 8'h90;
  localparam logic [7:0] OFS_RECENT_HI = 8'h94;

  localparam int CON_ON = 15;
  localparam int CON_SIZE = 14;
  localparam int CON_DIR = 13;
  localparam int CON_HALF = 12;
  localparam int CON_NULL_WR = 11;
  localparam int CON_ADDR_SEL = 4;
  localparam int CON_MODE = 0;
  localparam int REQ_FORCE = 15;

  localparam logic [15:0] CON_MASK = 16'hF833;
  localparam logic [15:0] HIGH_MASK = 16'h00FF;
  localparam logic [15:0] CNT_MASK = 16'h3FFF;
  localparam logic [15:0] CON_RESET = 16'h0000;
  localparam logic [3:0] LCA_RESET = 4'hF;

  localparam logic [1:0] ADDR_POSTINC = 2'h0;
  localparam logic [1:0] ADDR_NOINC = 2'h1;
  localparam logic [1:0] ADDR_PERIPH = 2'h2;
  // Operating mode bit 1 enables ping-pong, bit 0 makes it one-shot.
  localparam int MODE_PP = 1;
  localparam int MODE_ONESHOT = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] chan;
    logic [23:0] ram_addr;
    logic [15:0] periph_addr;
    logic to_periph;
    logic byte_size;
    logic null_write;
  } xfer_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0,
    ENG_BUSY = 2'h1
  } eng_state_t;
endpackage
`default_nettype wire

/* rtl/dma_channels.sv */
/*
  Four-channel DMA register set with request selection, fixed-priority
  arbitration and per-channel block sequencing, reached over AXI4-Lite.
  Assumes the data mover outside accepts one element at a time, holding
  xfer_valid high until it returns a one-cycle xfer_done, and that the
  peripheral request lines are one-cycle pulses on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module dma_channels #(
  parameter int IRQ_LINES = 256
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [dma_regs_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [dma_regs_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [IRQ_LINES-1:0] periph_irq,
  input wire logic [23:0] indirect_addr,
  output dma_regs_pkg::xfer_t xfer,
  output logic xfer_valid,
  input wire logic xfer_done,
  output logic [dma_regs_pkg::NUM_CH-1:0] channel_done_irq
);
  import dma_regs_pkg::*;

  logic [15:0] con [NUM_CH];
  logic [7:0] req_code [NUM_CH];
  logic [NUM_CH-1:0] force_on;
  logic [23:0] primary_start_address [NUM_CH];
  logic [23:0] stb [NUM_CH];
  logic [15:0] pad [NUM_CH];
  logic [13:0] cnt [NUM_CH];
  logic [13:0] elem_cnt [NUM_CH];
  logic [23:0] offset [NUM_CH];
  logic [NUM_CH-1:0] buf_b;
  logic [NUM_CH-1:0] pend;
  logic [NUM_CH-1:0] pwc;
  logic [NUM_CH-1:0] rqc;
  logic [3:0] lca;
  logic [23:0] dsadr;
  eng_state_t state;
  logic [1:0] cur;
  logic cur_forced;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  logic wr_fire;
  logic wr_chan_hit;
  logic [1:0] wr_ch;
  logic [2:0] wr_idx;
  logic [NUM_CH-1:0] req_evt;
  logic [NUM_CH-1:0] serve;
  logic [NUM_CH-1:0] done_ch;
  logic [NUM_CH-1:0] last_elem;
  logic [NUM_CH-1:0] half_hit;
  logic [NUM_CH-1:0] oneshot_end;
  logic [NUM_CH-1:0] ready_ch;
  logic [1:0] grant;
  logic any_ready;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign wr_fire = !s_awready && !s_wready && !s_bvalid;
  assign wr_chan_hit = !aw_addr[7];
  assign wr_ch = aw_addr[6:5];
  assign wr_idx = aw_addr[4:2];

  // Per-channel request, completion and block-boundary terms.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [14:0] n_moved;
    logic [14:0] half_pt;
    assign req_evt[c] = periph_irq[req_code[c]] && con[c][CON_ON];
    assign ready_ch[c] = (pend[c] || force_on[c]) && con[c][CON_ON];
    assign done_ch[c] = (state == ENG_BUSY) && xfer_done && (cur == 2'(c));
    assign n_moved = {1'b0, elem_cnt[c]} + 15'h0001;
    assign half_pt = ({1'b0, cnt[c]} + 15'h0001) >> 1;
    assign last_elem[c] = elem_cnt[c] == cnt[c];
    assign half_hit[c] = (n_moved == half_pt) && (half_pt != 15'h0000);
    // One-shot ping-pong ends only after the block from the second buffer.
    assign oneshot_end[c] = done_ch[c] && last_elem[c] && con[c][CON_MODE + MODE_ONESHOT]
                            && (!con[c][CON_MODE + MODE_PP] || buf_b[c]);
    assign serve[c] = done_ch[c];
  end

  // Fixed priority: channel 0 beats channel 3.
  always_comb begin
    grant = 2'h0;
    any_ready = |ready_ch;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (ready_ch[c]) begin
        grant = 2'(c);
      end
    end
  end

  // Write-address and write-data channels are taken in either order.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_awvalid && s_awready) begin
        s_awready <= 1'b0;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        s_wready <= 1'b0;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp <= (wr_chan_hit || aw_addr inside {OFS_PWC, OFS_RQC}) ? RESP_OKAY
                   : RESP_SLVERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // Channel registers; software writes and hardware clears share one process.
  always_ff @(posedge mclk) begin
    if (rst) begin
      force_on <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        con[c] <= CON_RESET;
        req_code[c] <= '0;
        primary_start_address[c] <= '0;
        stb[c] <= '0;
        pad[c] <= '0;
        cnt[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (oneshot_end[c]) begin
          con[c][CON_ON] <= 1'b0;
        end
        // Force falls after its transfer or once the channel is off.
        if ((serve[c] && cur_forced) || !con[c][CON_ON]) begin
          force_on[c] <= 1'b0;
        end
        if (wr_fire && wr_chan_hit && wr_ch == 2'(c)) begin
          case (wr_idx)
            IDX_CON: con[c] <= merge(con[c], w_data, w_strb) & CON_MASK;
            IDX_REQ: begin
              if (w_strb[0]) begin
                req_code[c] <= w_data[7:0];
              end
              // Writing zero never clears a pending force.
              if (w_strb[1] && w_data[REQ_FORCE]) begin
                force_on[c] <= 1'b1;
              end
            end
            IDX_STAH: primary_start_address[c][23:16] <= 8'(merge({8'h00, primary_start_address[c][23:16]}, w_data, w_strb));
            IDX_STAL: primary_start_address[c][15:0] <= merge(primary_start_address[c][15:0], w_data, w_strb);
            IDX_STBH: stb[c][23:16] <= 8'(merge({8'h00, stb[c][23:16]}, w_data, w_strb));
            IDX_STBL: stb[c][15:0] <= merge(stb[c][15:0], w_data, w_strb);
            IDX_PAD: pad[c] <= merge(pad[c], w_data, w_strb);
            IDX_CNT: cnt[c] <= 14'(merge({2'h0, cnt[c]}, w_data, w_strb) & CNT_MASK);
            default: ;
          endcase
        end
      end
    end
  end

  // Request capture and collision status; a new event beats a software clear.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend <= '0;
      pwc <= '0;
      rqc <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        logic clr_pwc;
        logic clr_rqc;
        logic force_wr;
        clr_pwc = wr_fire && aw_addr == OFS_PWC && w_strb[0] && w_data[c];
        clr_rqc = wr_fire && aw_addr == OFS_RQC && w_strb[0] && w_data[c];
        force_wr = wr_fire && wr_chan_hit && wr_ch == 2'(c) && wr_idx == IDX_REQ
                   && w_strb[1] && w_data[REQ_FORCE];
        pend[c] <= con[c][CON_ON] && ((pend[c] && !serve[c]) || req_evt[c]);
        // A request that lands on one still waiting is a collision.
        pwc[c] <= (pwc[c] && !clr_pwc) || (req_evt[c] && pend[c] && !serve[c]);
        rqc[c] <= (rqc[c] && !clr_rqc)
                  || (req_evt[c] && force_on[c]) || (force_wr && pend[c]);
      end
    end
  end

  // Engine: grant one element, wait for the mover, then advance the channel.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ENG_IDLE;
      cur <= '0;
      cur_forced <= 1'b0;
      xfer <= '0;
      xfer_valid <= 1'b0;
      lca <= LCA_RESET;
      dsadr <= '0;
    end else begin
      case (state)
        ENG_IDLE: begin
          if (any_ready) begin
            logic [23:0] base;
            logic [15:0] cc;
            cc = con[grant];
            base = buf_b[grant] ? stb[grant] : primary_start_address[grant];
            cur <= grant;
            cur_forced <= force_on[grant] && !pend[grant];
            xfer.chan <= grant;
            xfer.ram_addr <= (cc[CON_ADDR_SEL+:2] == ADDR_PERIPH) ? indirect_addr
                             : base + offset[grant];
            xfer.periph_addr <= pad[grant];
            xfer.to_periph <= cc[CON_DIR];
            xfer.byte_size <= cc[CON_SIZE];
            // Null writes are only issued for peripheral-to-RAM moves.
            xfer.null_write <= cc[CON_NULL_WR] && !cc[CON_DIR];
            dsadr <= (cc[CON_ADDR_SEL+:2] == ADDR_PERIPH) ? indirect_addr
                     : base + offset[grant];
            xfer_valid <= 1'b1;
            state <= ENG_BUSY;
          end
        end
        ENG_BUSY: begin
          if (xfer_done) begin
            xfer_valid <= 1'b0;
            lca <= {2'h0, cur};
            state <= ENG_IDLE;
          end
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end

  // Per-channel block progress and the completion pulse.
  always_ff @(posedge mclk) begin
    if (rst) begin
      buf_b <= '0;
      channel_done_irq <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        elem_cnt[c] <= '0;
        offset[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        channel_done_irq[c] <= done_ch[c] && (con[c][CON_HALF] ? half_hit[c]
                                                               : last_elem[c]);
        if (!con[c][CON_ON] && state == ENG_IDLE) begin
          elem_cnt[c] <= '0;
          offset[c] <= '0;
          buf_b[c] <= 1'b0;
        end else if (done_ch[c]) begin
          if (last_elem[c]) begin
            elem_cnt[c] <= '0;
            offset[c] <= '0;
            if (con[c][CON_MODE + MODE_PP]) begin
              buf_b[c] <= !buf_b[c];
            end
          end else begin
            elem_cnt[c] <= elem_cnt[c] + 14'h0001;
            if (con[c][CON_ADDR_SEL+:2] == ADDR_POSTINC) begin
              offset[c] <= offset[c] + (con[c][CON_SIZE] ? 24'h000001 : 24'h000002);
            end
          end
        end
      end
    end
  end

  // Read side: one cycle from address to data.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else begin
      if (s_arvalid && s_arready) begin
        logic [1:0] rc;
        logic [15:0] v;
        rc = s_araddr[6:5];
        v = 16'h0000;
        s_rresp <= RESP_OKAY;
        if (!s_araddr[7]) begin
          case (s_araddr[4:2])
            IDX_CON: v = con[rc];
            IDX_REQ: v = {force_on[rc], 7'h00, req_code[rc]};
            IDX_STAH: v = {8'h00, primary_start_address[rc][23:16]};
            IDX_STAL: v = primary_start_address[rc][15:0];
            IDX_STBH: v = {8'h00, stb[rc][23:16]};
            IDX_STBL: v = stb[rc][15:0];
            IDX_PAD: v = pad[rc];
            IDX_CNT: v = {2'h0, cnt[rc]};
            default: v = 16'h0000;
          endcase
        end else begin
          case (s_araddr)
            OFS_PWC: v = {12'h000, pwc};
            OFS_RQC: v = {12'h000, rqc};
            OFS_PPS: v = {12'h000, buf_b};
            OFS_LCA: v = {12'h000, lca};
            OFS_RECENT_LO: v = dsadr[15:0];
            OFS_RECENT_HI: v = {8'h00, dsadr[23:16]};
            default: s_rresp <= RESP_SLVERR;
          endcase
        end
        s_rdata <= {16'h0000, v};
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
      end
      if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* test/dma_channels_assertions.sv */
/*
  Port checker for the DMA register set: bus answers, mover link, pulses.
  Assumes only the top module's ports; it is bound at the foot of this file.
*/
`timescale 1ns/10ps
`default_nettype none
module dma_channels_assertions #(
  parameter int IRQ_LINES = 256
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [dma_regs_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [dma_regs_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [IRQ_LINES-1:0] periph_irq,
  input wire logic [23:0] indirect_addr,
  input wire dma_regs_pkg::xfer_t xfer,
  input wire logic xfer_valid,
  input wire logic xfer_done,
  input wire logic [dma_regs_pkg::NUM_CH-1:0] channel_done_irq
);
  import dma_regs_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence el_open;
    xfer_valid && !xfer_done;
  endsequence
  write_answer_a: assert property (wr_taken |-> ##[1:2] s_bvalid)
    else $error("write not answered");
  read_answer_a: assert property (s_arvalid && s_arready |-> ##[1:2] s_rvalid)
    else $error("read not answered");
  bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  upper_zero_a: assert property (s_rvalid |-> s_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  xfer_hold_a: assert property (el_open |=> xfer_valid && $stable(xfer))
    else $error("element changed in flight");
  valid_drop_a: assert property (xfer_valid && xfer_done |=> !xfer_valid)
    else $error("element not closed");
  done_cause_a: assert property (channel_done_irq != 4'h0 |-> $past(xfer_done) && $onehot(channel_done_irq))
    else $error("completion without element");
  done_pulse_a: assert property (channel_done_irq != 4'h0 |=> channel_done_irq == 4'h0)
    else $error("completion longer than a cycle");
endmodule
bind dma_channels dma_channels_assertions #(.IRQ_LINES(IRQ_LINES)) i_chk (.mclk, .rst,
  .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
  .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
  .s_rready, .periph_irq, .indirect_addr, .xfer, .xfer_valid, .xfer_done, .channel_done_irq);
`default_nettype wire

/* test/mover_model.sv */
/*
  Data mover stand-in: ends each element with a one-cycle done pulse.
  Assumes xfer_valid stays high until the cycle after done; delay sets its pace.
*/
`timescale 1ns/10ps
`default_nettype none
module mover_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic xfer_valid,
  input wire logic [7:0] delay,
  output logic xfer_done
);
  logic [7:0] cnt;
  logic fired;
  // One pulse per element; the fired flag stops a second pulse while valid falls.
  always_ff @(posedge mclk) begin
    if (rst || !xfer_valid) begin
      cnt <= 8'h00;
      fired <= 1'b0;
      xfer_done <= 1'b0;
    end else if (!fired && cnt >= delay) begin
      xfer_done <= 1'b1;
      fired <= 1'b1;
    end else begin
      xfer_done <= 1'b0;
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* test/four_channel_dma_register_set_tb.sv */
/*
  Self-checking bench for the DMA register set with a data mover stand-in.
  Assumes the package map and the hand-over timing of the register bus.
*/
`timescale 1ns/10ps
`default_nettype none
module four_channel_dma_register_set_tb;
  import dma_regs_pkg::*;
  localparam logic [15:0] MASKS [8] = '{16'h7833, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF,
    16'hFFFF, 16'hFFFF, 16'h3FFF};
  logic mclk = 1'b0, rst = 1'b1, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0, xv_d = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, delay = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'h3, channel_done_irq;
  logic [255:0] periph_irq = '0;
  logic [23:0] indirect_addr = 24'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, xfer_valid, xfer_done;
  logic [1:0] s_bresp, s_rresp;
  xfer_t xfer;
  xfer_t xq[$];
  logic [33:0] bq[$];
  logic [3:0] iq[$];
  int failures = 0, n_compared = 0, seed = 7330;

  dma_channels #(.IRQ_LINES(256)) i_dma_channels (.mclk, .rst, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .periph_irq,
    .indirect_addr, .xfer, .xfer_valid, .xfer_done, .channel_done_irq);
  mover_model i_mover_model (.mclk, .rst, .xfer_valid, .delay, .xfer_done);

  always #10 mclk = ~mclk;

  task automatic bad(input string m);
    failures++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic cmp_x(input xfer_t g, input xfer_t e);
    n_compared++;
    if (g !== e) bad($sformatf("element %h exp %h", g, e));
  endtask
  task automatic cmp_b(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) bad($sformatf("bus %h exp %h", g, e));
  endtask
  task automatic cmp_i(input logic [3:0] g, input logic [3:0] e);
    n_compared++;
    if (g !== e) bad($sformatf("done %h exp %h", g, e));
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Results are taken in arrival order; an empty queue means an unasked result.
  always @(posedge mclk) begin
    xv_d <= xfer_valid;
    if (s_bvalid && s_bready) cmp_b({s_bresp, 32'h0}, bq.size() ? bq.pop_front() : 34'h3);
    if (s_rvalid && s_rready) cmp_b({s_rresp, s_rdata}, bq.size() ? bq.pop_front() : 34'h3);
    if (xfer_valid && !xv_d) cmp_x(xfer, xq.size() ? xq.pop_front() : ~xfer);
    if (channel_done_irq != 4'h0) cmp_i(channel_done_irq, iq.size() ? iq.pop_front() : 4'h0);
  end

  function automatic logic [7:0] ad(input int c, input int r);
    return 8'(c * 32 + r * 4);
  endfunction
  function automatic xfer_t mk(input int c, input logic [23:0] a, input logic [15:0] p,
      input logic tp, input logic bs, input logic nw);
    return {2'(c), a, p, tp, bs, nw};
  endfunction

  task automatic bus(input bit w, input logic [7:0] a, input logic [15:0] d,
      input logic [33:0] e);
    int n;
    bq.push_back(e);
    if (w) begin
      s_awaddr <= a;
      s_wdata <= {16'h0000, d};
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
    end else begin
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
    end
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_arready) s_arvalid <= 1'b0;
      if (s_bvalid || s_rvalid) break;
    end
    s_bready <= 1'b0;
    s_rready <= 1'b0;
    @(posedge mclk);
    if (n == 40) begin
      bad("bus hang");
      test_done;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] rs);
    bus(1'b1, a, d, {rs, 32'h0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] rs);
    bus(1'b0, a, 16'h0000, {rs, 16'h0000, d});
  endtask
  task automatic prog(input int c, input logic [23:0] a, input logic [15:0] p,
      input logic [15:0] k, input logic [15:0] q, input logic [15:0] con);
    wr(ad(c, 2), {8'h00, a[23:16]}, RESP_OKAY);
    wr(ad(c, 3), a[15:0], RESP_OKAY);
    wr(ad(c, 6), p, RESP_OKAY);
    wr(ad(c, 7), k, RESP_OKAY);
    wr(ad(c, 1), q, RESP_OKAY);
    wr(ad(c, 0), con, RESP_OKAY);
  endtask
  task automatic pulse(input logic [7:0] code);
    periph_irq[code] <= 1'b1;
    @(posedge mclk);
    periph_irq <= '0;
    @(posedge mclk);
  endtask
  task automatic settle;
    int n;
    for (n = 0; n < 400 && (xq.size() + iq.size() != 0 || xfer_valid); n++) @(posedge mclk);
    if (n == 400) begin
      bad("transfer hang");
      test_done;
    end
  endtask

  initial begin
    int c, r, n;
    logic [15:0] v;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (c = 0; c < 4; c++) for (r = 0; r < 8; r++) rd(ad(c, r), 16'h0000, RESP_OKAY);
    rd(OFS_LCA, 16'h000F, RESP_OKAY);
    wr(8'h98, 16'hFFFF, RESP_SLVERR);
    rd(8'h98, 16'h0000, RESP_SLVERR);
    $display("reset values test done");
    for (c = 0; c < 4; c++) begin
      for (r = 0; r < 8; r++) begin
        v = 16'($random(seed));
        v[15] = (r == 0) ? 1'b0 : v[15];
        wr(ad(c, r), v, RESP_OKAY);
        rd(ad(c, r), v & MASKS[r], RESP_OKAY);
      end
    end
    $display("readback test done");
    delay <= {5'h00, v[2:0]};
    prog(1, 24'h123400, 16'h0248, 16'h0003, 16'h000A, 16'hD001);
    for (n = 0; n < 4; n++) begin
      xq.push_back(mk(1, 24'h123400 + 24'(n), 16'h0248, 1'b0, 1'b1, 1'b0));
      if (n == 1) iq.push_back(4'h2);
      pulse(8'h0A);
      settle;
    end
    rd(ad(1, 0), 16'h5001, RESP_OKAY);
    $display("one-shot byte test done");
    delay <= 8'h1E;
    wr(ad(0, 4), 16'h0002, RESP_OKAY);
    wr(ad(0, 5), 16'h2000, RESP_OKAY);
    prog(0, 24'h001000, 16'h0300, 16'h0001, 16'h00FF, 16'h8002);
    xq.push_back(mk(0, 24'h001000, 16'h0300, 1'b0, 1'b0, 1'b0));
    wr(ad(0, 1), 16'h80FF, RESP_OKAY);
    wr(ad(0, 1), 16'h00FF, RESP_OKAY);
    rd(ad(0, 1), 16'h80FF, RESP_OKAY);
    settle;
    rd(ad(0, 1), 16'h00FF, RESP_OKAY);
    delay <= 8'h00;
    for (n = 1; n < 5; n++) begin
      xq.push_back(mk(0, (n[1] ? 24'h022000 : 24'h001000) + 24'(2 * n[0]), 16'h0300,
        1'b0, 1'b0, 1'b0));
      if (n[0]) iq.push_back(4'h1);
      wr(ad(0, 1), 16'h80FF, RESP_OKAY);
      settle;
    end
    wr(ad(0, 0), 16'h0000, RESP_OKAY);
    $display("ping-pong force test done");
    v = 16'($random(seed));
    indirect_addr <= {v[7:0], v};
    prog(2, {8'h00, v}, 16'h0224, 16'h0000, 16'h005B, 16'hA001);
    prog(3, 24'h000000, 16'h02A8, 16'h0000, 16'h005B, 16'h8821);
    xq.push_back(mk(2, {8'h00, v}, 16'h0224, 1'b1, 1'b0, 1'b0));
    iq.push_back(4'h4);
    xq.push_back(mk(3, {v[7:0], v}, 16'h02A8, 1'b0, 1'b0, 1'b1));
    iq.push_back(4'h8);
    pulse(8'h5B);
    settle;
    rd(OFS_LCA, 16'h0003, RESP_OKAY);
    rd(ad(2, 0), 16'h2001, RESP_OKAY);
    $display("priority test done");
    test_done;
  end
endmodule
`default_nettype wire
